/* core/rbc_consts.svh */
// Offsets, field positions, reset values and timing counts of the block
`ifndef RBC_CONSTS_SVH
`define RBC_CONSTS_SVH

// Register indices on the plain register port
`define RBC_REG_PORT_DATA 4'h0
`define RBC_REG_PORT_DIR 4'h1
`define RBC_REG_SEG_CTRL 4'h2
`define RBC_REG_STATUS 4'h3

// Status register field positions
`define RBC_ST_CODE_LSB 0
`define RBC_ST_EXT_BIT 3
`define RBC_ST_RSVD_BIT 4
`define RBC_ST_INIT_BIT 5
`define RBC_ST_SRC_LSB 6

// Reset values
`define RBC_PORT_DATA_RST 2'h0
`define RBC_PORT_DIR_RST 2'h0
`define RBC_SEG_EN_RST 2'h0
`define RBC_STRAP_RST 3'h4

// Timing: clock period and least low time of the reset pin
`define RBC_CLK_NS 10
`define RBC_RST_MIN_NS 500
`define RBC_RST_MIN_CYC \
  ((`RBC_RST_MIN_NS + `RBC_CLK_NS - 1) / `RBC_CLK_NS)
// Internal reset length after a software or watchdog request
`define RBC_INT_RST_CYC 8

`endif

/* core/rbc_pkg.sv */
// Types and decode functions of the reset and bus configuration block
`default_nettype none
package rbc_pkg;

  typedef enum logic [2:0] {
    MODE_DEMUX8,
    MODE_MUX8,
    MODE_MUX16,
    MODE_DEMUX16,
    MODE_SINGLE,
    MODE_RESERVED
  } bus_mode_type;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_INIT,
    ST_RUN
  } reset_state_type;

  // Strap code {bus active, cfg1, cfg0} to bus mode
  function automatic bus_mode_type decode_mode(input logic [2:0] code);
    case (code)
      3'h0: decode_mode = MODE_DEMUX8;
      3'h1: decode_mode = MODE_MUX8;
      3'h2: decode_mode = MODE_MUX16;
      3'h3: decode_mode = MODE_DEMUX16;
      3'h4: decode_mode = MODE_SINGLE;
      default: decode_mode = MODE_RESERVED;
    endcase
  endfunction

  // True for the four external bus configurations
  function automatic logic is_ext_bus(input bus_mode_type mode);
    is_ext_bus = (mode == MODE_DEMUX8) || (mode == MODE_MUX8) ||
                 (mode == MODE_MUX16) || (mode == MODE_DEMUX16);
  endfunction

endpackage
`default_nettype wire

/* core/reset_and_bus_config_select.sv */
// Reset entry, strap capture, reset indication and segment port logic
//
// Functional notes
// - Capture bus straps while reset is active
// - Decode straps into one of five modes, codes above 4 reserved
// - Reset pin low for least duration resets
// - Indication low on hardware, software, watchdog reset
// - Indication released only by end-of-init
// - Two-bit port, per-bit direction control
// - Input bits leave the pin undriven
// - External bus drives segment address onto port
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "rbc_consts.svh"
module reset_and_bus_config_select #(
  parameter int RST_MIN_CYC = `RBC_RST_MIN_CYC,
  parameter int INT_RST_CYC = `RBC_INT_RST_CYC
) (
  // Clock and block reset
  input wire logic clk,
  input wire logic resetn,
  // Reset pin and internal reset requests
  input wire logic reset_input_pin,
  input wire logic sw_reset_req,
  input wire logic wdt_reset_req,
  input wire logic end_of_init_instruction,
  // Bus configuration straps
  input wire logic bus_active_select,
  input wire logic bus_cfg_bit1,
  input wire logic bus_cfg_bit0,
  // Segment address from the bus unit
  input wire logic segment_addr_low,
  input wire logic segment_addr_high,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Two-bit port pins
  input wire logic segment_port_bit0_in,
  input wire logic segment_port_bit1_in,
  output logic segment_port_bit0_out,
  output logic segment_port_bit1_out,
  output logic segment_port_bit0_oe,
  output logic segment_port_bit1_oe,
  // Reset and mode outputs
  output logic reset_indication_out,
  output logic core_reset_n,
  output rbc_pkg::bus_mode_type bus_mode,
  output logic ext_bus_active
);
  import rbc_pkg::*;

  localparam int CW = $clog2(INT_RST_CYC + 1);

  logic hw_reset;
  logic reset_event;
  logic [2:0] strap_now;
  logic [1:0] pin_in;
  logic [1:0] seg_addr;

  // Reset controller state
  reset_state_type state_r;
  reset_state_type state_nxt;
  logic [CW-1:0] hold_cnt_r;
  logic [CW-1:0] hold_cnt_nxt;
  logic [2:0] strap_r;
  logic [2:0] strap_nxt;
  bus_mode_type mode_r;
  bus_mode_type mode_nxt;
  logic [2:0] code_r;
  logic [2:0] code_nxt;
  logic rst_ind_r;
  logic rst_ind_nxt;
  logic core_rst_n_r;
  logic core_rst_n_nxt;
  logic ext_r;
  logic ext_nxt;

  // Software visible state
  logic [1:0] data_r;
  logic [1:0] data_nxt;
  logic [1:0] dir_r;
  logic [1:0] dir_nxt;
  logic [1:0] seg_en_r;
  logic [1:0] seg_en_nxt;
  logic [2:0] src_r;
  logic [2:0] src_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;

  // Pin state
  logic [1:0] pin_in_r;
  logic [1:0] pin_out_r;
  logic [1:0] pin_out_nxt;
  logic [1:0] pin_oe_r;
  logic [1:0] pin_oe_nxt;

  // Reset pin qualification
  reset_in_filter #(
    .MIN_CYC(RST_MIN_CYC)
  ) u_filter (
    .clk(clk),
    .resetn(resetn),
    .reset_input_pin(reset_input_pin),
    .hw_reset(hw_reset)
  );

  // Gathered inputs
  assign strap_now = {bus_active_select, bus_cfg_bit1, bus_cfg_bit0};
  assign pin_in = {segment_port_bit1_in, segment_port_bit0_in};
  assign seg_addr = {segment_addr_high, segment_addr_low};
  assign reset_event = hw_reset || sw_reset_req || wdt_reset_req;

  // Reset sequencing, strap capture and mode latch
  always_comb begin
    state_nxt = state_r;
    hold_cnt_nxt = hold_cnt_r;
    strap_nxt = strap_r;
    mode_nxt = mode_r;
    code_nxt = code_r;
    case (state_r)
      ST_HOLD: begin
        strap_nxt = strap_now;
        if (hw_reset) begin
          hold_cnt_nxt = '0;
        end else if (hold_cnt_r == CW'(INT_RST_CYC - 1)) begin
          hold_cnt_nxt = '0;
          state_nxt = ST_INIT;
          code_nxt = strap_r;
          mode_nxt = decode_mode(strap_r);
        end else begin
          hold_cnt_nxt = hold_cnt_r + 1'b1;
        end
      end
      ST_INIT: begin
        if (reset_event) begin
          state_nxt = ST_HOLD;
        end else if (end_of_init_instruction) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (reset_event) begin
          state_nxt = ST_HOLD;
        end
      end
      default: begin
        state_nxt = ST_HOLD;
        hold_cnt_nxt = '0;
      end
    endcase
    // Indication high only once initialization has ended
    rst_ind_nxt = (state_nxt == ST_RUN);
    core_rst_n_nxt = (state_nxt != ST_HOLD);
    ext_nxt = is_ext_bus(mode_nxt);
  end

  // Register the sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= ST_HOLD;
      hold_cnt_r <= '0;
      strap_r <= `RBC_STRAP_RST;
      code_r <= `RBC_STRAP_RST;
      mode_r <= MODE_SINGLE;
      rst_ind_r <= 1'b0;
      core_rst_n_r <= 1'b0;
      ext_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      strap_r <= strap_nxt;
      code_r <= code_nxt;
      mode_r <= mode_nxt;
      rst_ind_r <= rst_ind_nxt;
      core_rst_n_r <= core_rst_n_nxt;
      ext_r <= ext_nxt;
    end
  end

  // Register writes and reset source flags
  always_comb begin
    data_nxt = data_r;
    dir_nxt = dir_r;
    seg_en_nxt = seg_en_r;
    src_nxt = src_r;
    if (!core_rst_n_r) begin
      data_nxt = `RBC_PORT_DATA_RST;
      dir_nxt = `RBC_PORT_DIR_RST;
      seg_en_nxt = `RBC_SEG_EN_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `RBC_REG_PORT_DATA: data_nxt = reg_wdata[1:0];
        `RBC_REG_PORT_DIR: dir_nxt = reg_wdata[1:0];
        `RBC_REG_SEG_CTRL: seg_en_nxt = reg_wdata[1:0];
        `RBC_REG_STATUS: begin
          src_nxt = src_r & ~reg_wdata[`RBC_ST_SRC_LSB +: 3];
        end
        default: begin
        end
      endcase
    end
    // A new reset source wins over a clear in the same cycle
    if (state_r != ST_HOLD) begin
      src_nxt = src_nxt | {wdt_reset_req, sw_reset_req, hw_reset};
    end else if (hw_reset) begin
      src_nxt[0] = 1'b1;
    end
  end

  // Register the software state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      data_r <= `RBC_PORT_DATA_RST;
      dir_r <= `RBC_PORT_DIR_RST;
      seg_en_r <= `RBC_SEG_EN_RST;
      src_r <= 3'h0;
    end else begin
      data_r <= data_nxt;
      dir_r <= dir_nxt;
      seg_en_r <= seg_en_nxt;
      src_r <= src_nxt;
    end
  end

  // Read data, standing one cycle after the read strobe
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `RBC_REG_PORT_DATA: rdata_nxt = {12'h000, pin_in_r, data_r};
        `RBC_REG_PORT_DIR: rdata_nxt = {14'h0000, dir_r};
        `RBC_REG_SEG_CTRL: rdata_nxt = {14'h0000, seg_en_r};
        `RBC_REG_STATUS: begin
          rdata_nxt[`RBC_ST_CODE_LSB +: 3] = code_r;
          rdata_nxt[`RBC_ST_EXT_BIT] = ext_r;
          rdata_nxt[`RBC_ST_RSVD_BIT] = (mode_r == MODE_RESERVED);
          rdata_nxt[`RBC_ST_INIT_BIT] = (state_r == ST_INIT);
          rdata_nxt[`RBC_ST_SRC_LSB +: 3] = src_r;
        end
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Register read data
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Per-bit port drive selection
  generate
    for (genvar i = 0; i < 2; i++) begin : g_port
      always_comb begin
        if (ext_r && seg_en_r[i]) begin
          pin_out_nxt[i] = seg_addr[i];
          pin_oe_nxt[i] = 1'b1;
        end else begin
          // Single-chip, reserved mode or disabled segment: general purpose
          pin_out_nxt[i] = data_r[i];
          pin_oe_nxt[i] = dir_r[i];
        end
      end
    end
  endgenerate

  // Register pin drive and sample pin levels
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_out_r <= 2'h0;
      pin_oe_r <= 2'h0;
      pin_in_r <= 2'h0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      pin_in_r <= pin_in;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_r;
  assign segment_port_bit0_out = pin_out_r[0];
  assign segment_port_bit1_out = pin_out_r[1];
  assign segment_port_bit0_oe = pin_oe_r[0];
  assign segment_port_bit1_oe = pin_oe_r[1];
  assign reset_indication_out = rst_ind_r;
  assign core_reset_n = core_rst_n_r;
  assign bus_mode = mode_r;
  assign ext_bus_active = ext_r;
endmodule
`default_nettype wire

/* core/reset_in_filter.sv */
// Least-duration filter for the active-low reset input pin
`timescale 1ns/1ps
`default_nettype none
module reset_in_filter #(
  parameter int MIN_CYC = 50
) (
  // Clock and block reset
  input wire logic clk,
  input wire logic resetn,
  // Reset pin, active low
  input wire logic reset_input_pin,
  // Qualified hardware reset request
  output logic hw_reset
);
  localparam int W = $clog2(MIN_CYC + 1);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic hw_reset_r;
  logic hw_reset_nxt;

  // Count consecutive low cycles, saturating at the least duration
  always_comb begin
    cnt_nxt = cnt_r;
    if (reset_input_pin) begin
      cnt_nxt = '0;
    end else if (cnt_r != W'(MIN_CYC)) begin
      cnt_nxt = cnt_r + 1'b1;
    end
    hw_reset_nxt = (cnt_nxt == W'(MIN_CYC));
  end

  // Register counter and request
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_r <= '0;
      hw_reset_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      hw_reset_r <= hw_reset_nxt;
    end
  end

  assign hw_reset = hw_reset_r;
endmodule
`default_nettype wire

/* tb/rbc_board.sv */
// Board model: strap resistors and the two port pins
`timescale 1ns/1ps
`default_nettype none
module rbc_board (
  // Clock and board settings
  input wire logic clk,
  input wire logic romless,
  input wire logic [2:0] strap_code,
  input wire logic [1:0] ext_drv,
  input wire logic [1:0] ext_val,
  // Device pin drive
  input wire logic [1:0] dev_out,
  input wire logic [1:0] dev_oe,
  // Levels seen by the device
  output logic [2:0] straps,
  output logic [1:0] pin
);
  logic [1:0] wander_r = 2'h0;
  // Romless board ties bus-active low
  assign straps = {strap_code[2] & ~romless, strap_code[1:0]};
  // Undriven pins hold no value
  always_ff @(posedge clk) wander_r <= ~wander_r;
  // Pin level: device first, then board, else wandering
  assign pin = (dev_oe & dev_out) | (~dev_oe & ext_drv & ext_val) |
    (~dev_oe & ~ext_drv & wander_r);
endmodule
`default_nettype wire

/* tb/reset_and_bus_config_select_props.sv */
// Checker for the reset and bus configuration block
`timescale 1ns/1ps
`default_nettype none
module rbc_props
  import rbc_pkg::*;
#(
  parameter int RST_MIN_CYC = 50,
  parameter int INT_RST_CYC = 8
) (
  // Watched ports
  input wire logic clk,
  input wire logic resetn,
  input wire logic reset_input_pin,
  input wire logic sw_reset_req,
  input wire logic wdt_reset_req,
  input wire logic end_of_init_instruction,
  input wire logic bus_active_select,
  input wire logic bus_cfg_bit1,
  input wire logic bus_cfg_bit0,
  input wire logic segment_port_bit0_oe,
  input wire logic segment_port_bit1_oe,
  input wire logic reset_indication_out,
  input wire logic core_reset_n,
  input wire rbc_pkg::bus_mode_type bus_mode
);
  logic [7:0] low_r, low_nxt;
  logic [2:0] code;
  assign code = {bus_active_select, bus_cfg_bit1, bus_cfg_bit0};
  // Saturating count of consecutive low pin samples
  always_comb low_nxt = reset_input_pin ? 8'h0 : low_r + (low_r != 8'hff);
  always_ff @(posedge clk) low_r <= resetn ? low_nxt : 8'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_sw;
    core_reset_n && sw_reset_req |=> !core_reset_n && !reset_indication_out;
  endproperty
  a_sw: assert property (p_sw) else $error("sw reset missed");
  property p_wdt;
    core_reset_n && wdt_reset_req |=> !core_reset_n && !reset_indication_out;
  endproperty
  a_wdt: assert property (p_wdt) else $error("wdt reset missed");
  property p_pin;
    low_r > RST_MIN_CYC |-> !core_reset_n && !reset_indication_out;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset missed");
  property p_rise;
    $rose(reset_indication_out) |-> $past(end_of_init_instruction);
  endproperty
  a_rise: assert property (p_rise) else $error("early release");
  property p_rel;
    core_reset_n && !reset_indication_out && end_of_init_instruction &&
      !sw_reset_req && !wdt_reset_req && reset_input_pin &&
      $past(reset_input_pin) |=> reset_indication_out;
  endproperty
  a_rel: assert property (p_rel) else $error("no release");
  property p_hold;
    core_reset_n && $past(core_reset_n) |-> $stable(bus_mode);
  endproperty
  a_hold: assert property (p_hold) else $error("mode moved");
  // Mode comes from the straps seen in the next-to-last hold cycle, two edges back
  property p_dec;
    $rose(core_reset_n) |-> bus_mode == ($past(code, 2) > 3'h4 ?
      MODE_RESERVED : bus_mode_type'($past(code, 2)));
  endproperty
  a_dec: assert property (p_dec) else $error("bad decode");
  property p_oe;
    !core_reset_n [*3] |-> !segment_port_bit0_oe && !segment_port_bit1_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("pin driven");
  c_rel: cover property ($rose(reset_indication_out));
  c_pin: cover property (low_r > RST_MIN_CYC);
  c_ext: cover property (core_reset_n && bus_mode == MODE_DEMUX16);
endmodule
bind reset_and_bus_config_select rbc_props #(.RST_MIN_CYC(RST_MIN_CYC),
  .INT_RST_CYC(INT_RST_CYC)) chk_u (.clk, .resetn, .reset_input_pin,
  .sw_reset_req, .wdt_reset_req, .end_of_init_instruction,
  .bus_active_select, .bus_cfg_bit1, .bus_cfg_bit0, .segment_port_bit0_oe,
  .segment_port_bit1_oe, .reset_indication_out, .core_reset_n, .bus_mode);
`default_nettype wire

/* tb/tb_reset_and_bus_config_select.sv */
// Self-checking bench of the reset and bus configuration block
`timescale 1ns/1ps
`default_nettype none
`include "rbc_consts.svh"
module tb_reset_and_bus_config_select;
  import rbc_pkg::*;
  localparam int NMIN = 4;
  logic clk = 1'b0, resetn = 1'b0, pin_n = 1'b1, sw = 1'b0, wdt = 1'b0;
  logic eoi = 1'b0, romless = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [1:0] seg = 2'h0, pin, out, oe;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0, rdata;
  logic [2:0] strap_code = 3'h4, straps;
  logic ind, core_n, ext;
  bus_mode_type mode;
  int fails = 0, num_checks = 0;
  // Free-running clock
  always #5 clk = ~clk;
  rbc_board brd_u (.clk, .romless, .strap_code, .ext_drv(2'h2),
    .ext_val(2'h0), .dev_out(out), .dev_oe(oe), .straps, .pin);
  reset_and_bus_config_select #(.RST_MIN_CYC(NMIN), .INT_RST_CYC(2)) dut_u (
    .clk, .resetn, .reset_input_pin(pin_n), .sw_reset_req(sw),
    .wdt_reset_req(wdt), .end_of_init_instruction(eoi),
    .bus_active_select(straps[2]), .bus_cfg_bit1(straps[1]),
    .bus_cfg_bit0(straps[0]), .segment_addr_low(seg[0]),
    .segment_addr_high(seg[1]), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .segment_port_bit0_in(pin[0]), .segment_port_bit1_in(pin[1]),
    .segment_port_bit0_out(out[0]), .segment_port_bit1_out(out[1]),
    .segment_port_bit0_oe(oe[0]), .segment_port_bit1_oe(oe[1]),
    .reset_indication_out(ind), .core_reset_n(core_n), .bus_mode(mode),
    .ext_bus_active(ext));
  task automatic final_report;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // Bounded wait for the core to leave reset
  task automatic wait_run;
    for (int i = 0; i < 40 && core_n !== 1'b1; i++) cyc(1);
    if (core_n !== 1'b1) begin
      fails++;
      final_report();
    end
  endtask
  // Reset of kind k (0 sw, 1 wdt, 2 pin) with straps c, then end init
  task automatic do_reset(input int k, input logic [2:0] c);
    logic [2:0] e;
    logic [15:0] st;
    bus_mode_type m;
    @(posedge clk);
    // Straps as the board shows them, once the romless setting has settled
    e = {c[2] & ~romless, c[1:0]};
    m = e > 3'h4 ? MODE_RESERVED : bus_mode_type'(e);
    st = {7'h0, 3'h1 << ((k + 1) % 3), 1'b1, e > 3'h4, e < 3'h4, e};
    strap_code <= c;
    sw <= k == 0;
    wdt <= k == 1;
    pin_n <= k != 2;
    cyc(k == 2 ? NMIN + 3 : 1);
    sw <= 1'b0;
    wdt <= 1'b0;
    pin_n <= 1'b1;
    chk(16'({core_n, ind}), 16'h0);
    wait_run();
    cyc(2);
    chk(16'(ind), 16'h0);
    rd_reg(`RBC_REG_STATUS, st);
    chk(16'(mode), 16'(m));
    chk(16'(ext), 16'(e < 3'h4));
    wr_reg(`RBC_REG_STATUS, 16'h01c0);
    @(posedge clk);
    eoi <= 1'b1;
    cyc(1);
    eoi <= 1'b0;
    chk(16'(ind), 16'h1);
    strap_code <= ~c;
    cyc(3);
    chk(16'(mode), 16'(m));
  endtask
  // Main sequence
  initial begin
    cyc(16);
    resetn <= 1'b1;
    wait_run();
    rd_reg(`RBC_REG_PORT_DIR, 16'h0);
    rd_reg(4'hf, 16'h0);
    for (int c = 0; c < 8; c++) do_reset(0, 3'(c));
    do_reset(1, 3'h4);
    do_reset(2, 3'h4);
    pin_n <= 1'b0;
    cyc(NMIN - 1);
    pin_n <= 1'b1;
    cyc(4);
    chk(16'(core_n), 16'h1);
    $display("reset test done");
    wr_reg(`RBC_REG_PORT_DIR, 16'h1);
    wr_reg(`RBC_REG_PORT_DATA, 16'h3);
    wr_reg(`RBC_REG_SEG_CTRL, 16'h3);
    cyc(2);
    chk({12'h0, oe, out}, 16'h7);
    rd_reg(`RBC_REG_PORT_DATA, 16'h7);
    romless <= 1'b1;
    do_reset(0, 3'h6);
    romless <= 1'b0;
    chk({12'h0, oe, out}, 16'h0);
    wr_reg(`RBC_REG_SEG_CTRL, 16'h3);
    seg <= 2'h1;
    cyc(2);
    chk({12'h0, oe, out}, 16'hd);
    seg <= 2'h2;
    cyc(2);
    chk({12'h0, oe, out}, 16'he);
    $display("port test done");
    resetn <= 1'b0;
    cyc(2);
    chk(16'({mode, ind}), 16'(8));
    resetn <= 1'b1;
    wait_run();
    // Straps left at 3'b001 by the last scenario: 8-bit multiplexed
    chk(16'(mode), 16'(MODE_MUX8));
    $display("second reset test done");
    final_report();
  end
endmodule
`default_nettype wire
